// [src/lsag_pkg.sv]
// Package of constants and types for the load/store address generation unit
package lsag_pkg;

  localparam int unsigned LSAG_XLEN = 32;
  localparam logic [3:0] LSAG_REG_SP = 4'hd;
  localparam logic [3:0] LSAG_REG_PC = 4'hf;

  // Offset limits, as signed magnitudes
  localparam logic signed [13:0] LSAG_PCREL_MIN = -14'sd4095;
  localparam logic signed [13:0] LSAG_PCREL_MAX = 14'sd4095;
  localparam logic signed [13:0] LSAG_OFS_MIN = -14'sd255;
  localparam logic signed [13:0] LSAG_OFS_MAX = 14'sd4095;
  localparam logic signed [13:0] LSAG_IDX_MAX = 14'sd255;
  localparam logic signed [13:0] LSAG_DUAL_MIN = -14'sd1020;
  localparam logic signed [13:0] LSAG_DUAL_MAX = 14'sd1020;
  localparam logic [31:0] LSAG_DUAL_STEP = 32'h0000_0004;

  // Reset values
  localparam logic [31:0] LSAG_RST_WORD = 32'h0000_0000;
  localparam logic [3:0] LSAG_RST_REG = 4'h0;

  typedef enum logic [1:0] {
    LSAG_OP_PCREL = 2'b00,
    LSAG_OP_LOAD = 2'b01,
    LSAG_OP_STORE = 2'b10
  } lsag_op_t;

  typedef enum logic [1:0] {
    LSAG_MODE_OFFSET = 2'b00,
    LSAG_MODE_PRE = 2'b01,
    LSAG_MODE_POST = 2'b10
  } lsag_mode_t;

  typedef enum logic [2:0] {
    LSAG_SZ_BYTE = 3'b000,
    LSAG_SZ_HALF = 3'b001,
    LSAG_SZ_WORD = 3'b010,
    LSAG_SZ_SBYTE = 3'b011,
    LSAG_SZ_SHALF = 3'b100,
    LSAG_SZ_DUAL = 3'b101
  } lsag_size_t;

  typedef enum logic [2:0] {
    LSAG_ST_IDLE = 3'b000,
    LSAG_ST_MEM1 = 3'b001,
    LSAG_ST_MEM2 = 3'b010,
    LSAG_ST_DONE = 3'b011
  } lsag_state_t;

endpackage : lsag_pkg

// [src/lsag_extend.sv]
// Load data extension: zero or sign extension of bytes and halfwords
`timescale 1ns/1ps
module lsag_extend
  import lsag_pkg::*;
(
  // Raw data and size
  input wire logic [31:0] raw_data,
  input wire lsag_size_t size,
  // Extended word
  output logic [31:0] ext_data
);

  always_comb begin
    case (size)
      LSAG_SZ_BYTE: ext_data = {24'h00_0000, raw_data[7:0]};
      LSAG_SZ_HALF: ext_data = {16'h0000, raw_data[15:0]};
      LSAG_SZ_SBYTE: ext_data = {{24{raw_data[7]}}, raw_data[7:0]};
      LSAG_SZ_SHALF: ext_data = {{16{raw_data[15]}}, raw_data[15:0]};
      default: ext_data = raw_data;
    endcase
  end

endmodule : lsag_extend

// [src/lsag_unit.sv]
// Load/store address generation and execution unit for immediate-offset forms
// Operation
// - PC-relative generate adds immediate to PC, writes destination, flags untouched.
// - PC-relative immediate limited to -4095..+4095.
// - Offset mode accesses base plus/minus offset, base unchanged.
// - Pre-indexed accesses base plus/minus offset and writes it back.
// - Post-indexed accesses unmodified base, then writes back base plus/minus offset.
// - Unsigned byte/halfword loads zero-extend; signed forms sign-extend to 32 bits.
// - Single transfers accept -255..4095 offset mode, -255..255 indexed modes.
// - Dual transfers accept multiples of 4 within -1020..1020.
// - Word load into PC branches to loaded value with bit 0 cleared.
// - Immediate loads and stores leave condition flags unchanged.
`timescale 1ns/1ps
module lsag_unit
  import lsag_pkg::*;
(
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Instruction request
  input wire logic req_valid,
  output logic req_ready,
  input wire lsag_op_t req_op,
  input wire lsag_mode_t req_mode,
  input wire lsag_size_t req_size,
  input wire logic [3:0] req_rt,
  input wire logic [3:0] req_rt2,
  input wire logic [3:0] req_rn,
  input wire logic signed [13:0] req_imm,
  // Register operand values
  input wire logic [31:0] pc_value,
  input wire logic [31:0] base_value,
  input wire logic [31:0] rt_value,
  input wire logic [31:0] rt2_value,
  // Memory port
  output logic mem_valid,
  input wire logic mem_ready,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output logic [31:0] mem_wdata,
  output lsag_size_t mem_size,
  input wire logic [31:0] mem_rdata,
  // Register write-back and branch
  output logic wb_valid,
  output logic [3:0] wb_reg,
  output logic [31:0] wb_data,
  output logic wb2_valid,
  output logic [3:0] wb2_reg,
  output logic [31:0] wb2_data,
  output logic base_wb_valid,
  output logic [3:0] base_wb_reg,
  output logic [31:0] base_wb_data,
  output logic branch_valid,
  output logic [31:0] branch_target,
  output logic flags_write,
  output logic imm_error,
  output logic done
);

  typedef struct packed {
    lsag_state_t state;
    lsag_op_t op;
    lsag_mode_t mode;
    lsag_size_t size;
    logic [3:0] rt;
    logic [3:0] rt2;
    logic [3:0] rn;
    logic [31:0] addr;
    logic [31:0] new_base;
    logic [31:0] d2;
    logic mem_valid;
    logic mem_write;
    logic [31:0] mem_addr;
    logic [31:0] mem_wdata;
    logic wb_valid;
    logic [31:0] wb_data;
    logic wb2_valid;
    logic [31:0] wb2_data;
    logic base_wb_valid;
    logic branch_valid;
    logic [31:0] branch_target;
    logic imm_error;
    logic done;
  } lsag_regs_t;

  lsag_regs_t r;
  lsag_regs_t next_r;
  logic [31:0] ext_data;
  logic [31:0] imm_ext;
  logic [31:0] sum;
  logic imm_ok;

  lsag_extend u_extend (
    .raw_data(mem_rdata),
    .size(r.size),
    .ext_data(ext_data)
  );

  // Sign-extended immediate and PC or base plus/minus offset
  assign imm_ext = {{18{req_imm[13]}}, req_imm};
  assign sum = (req_op == LSAG_OP_PCREL) ? pc_value + imm_ext : base_value + imm_ext;

  // Immediate legality per form
  always_comb begin
    if (req_op == LSAG_OP_PCREL) begin
      imm_ok = (req_imm >= LSAG_PCREL_MIN) && (req_imm <= LSAG_PCREL_MAX);
    end else if (req_size == LSAG_SZ_DUAL) begin
      imm_ok = (req_imm >= LSAG_DUAL_MIN) && (req_imm <= LSAG_DUAL_MAX) && (req_imm[1:0] == 2'h0);
    end else if (req_mode == LSAG_MODE_OFFSET) begin
      imm_ok = (req_imm >= LSAG_OFS_MIN) && (req_imm <= LSAG_OFS_MAX);
    end else begin
      imm_ok = (req_imm >= LSAG_OFS_MIN) && (req_imm <= LSAG_IDX_MAX);
    end
  end

  assign req_ready = (r.state == LSAG_ST_IDLE);

  always_comb begin
    next_r = r;
    next_r.wb_valid = 1'b0;
    next_r.wb2_valid = 1'b0;
    next_r.base_wb_valid = 1'b0;
    next_r.branch_valid = 1'b0;
    next_r.imm_error = 1'b0;
    next_r.done = 1'b0;
    case (r.state)
      LSAG_ST_IDLE: begin
        if (req_valid) begin
          next_r.op = req_op;
          next_r.mode = req_mode;
          next_r.size = req_size;
          // Register restrictions are not screened; breaking them gives no defined result
          next_r.rt = req_rt;
          next_r.rt2 = req_rt2;
          next_r.rn = req_rn;
          next_r.new_base = sum;
          next_r.d2 = rt2_value;
          if (!imm_ok) begin
            // Out-of-range immediate: no access, no write-back
            next_r.imm_error = 1'b1;
            next_r.done = 1'b1;
          end else if (req_op == LSAG_OP_PCREL) begin
            next_r.wb_valid = 1'b1;
            next_r.wb_data = sum;
            next_r.done = 1'b1;
          end else begin
            // Post-indexed uses the unmodified base as access address
            next_r.addr = (req_mode == LSAG_MODE_POST) ? base_value : sum;
            next_r.mem_valid = 1'b1;
            next_r.mem_write = (req_op == LSAG_OP_STORE);
            next_r.mem_addr = (req_mode == LSAG_MODE_POST) ? base_value : sum;
            next_r.mem_wdata = rt_value;
            next_r.state = LSAG_ST_MEM1;
          end
        end
      end
      LSAG_ST_MEM1: begin
        if (mem_ready) begin
          if (r.op == LSAG_OP_LOAD) begin
            if (r.rt == LSAG_REG_PC && r.size == LSAG_SZ_WORD) begin
              next_r.branch_valid = 1'b1;
              next_r.branch_target = {mem_rdata[31:1], 1'b0};
            end else begin
              next_r.wb_valid = 1'b1;
              next_r.wb_data = ext_data;
            end
          end
          if (r.size == LSAG_SZ_DUAL) begin
            next_r.mem_addr = r.addr + LSAG_DUAL_STEP;
            next_r.mem_wdata = r.d2;
            next_r.state = LSAG_ST_MEM2;
          end else begin
            next_r.mem_valid = 1'b0;
            next_r.state = LSAG_ST_DONE;
          end
        end
      end
      LSAG_ST_MEM2: begin
        if (mem_ready) begin
          next_r.wb2_valid = (r.op == LSAG_OP_LOAD);
          next_r.wb2_data = mem_rdata;
          next_r.mem_valid = 1'b0;
          next_r.state = LSAG_ST_DONE;
        end
      end
      LSAG_ST_DONE: begin
        // Offset mode leaves the base alone
        next_r.base_wb_valid = (r.mode != LSAG_MODE_OFFSET);
        next_r.done = 1'b1;
        next_r.state = LSAG_ST_IDLE;
      end
      default: begin
        next_r.state = LSAG_ST_IDLE;
        next_r.mem_valid = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  assign mem_valid = r.mem_valid;
  assign mem_write = r.mem_write;
  assign mem_addr = r.mem_addr;
  assign mem_wdata = r.mem_wdata;
  assign mem_size = r.size;
  assign wb_valid = r.wb_valid;
  assign wb_reg = r.rt;
  assign wb_data = r.wb_data;
  assign wb2_valid = r.wb2_valid;
  assign wb2_reg = r.rt2;
  assign wb2_data = r.wb2_data;
  assign base_wb_valid = r.base_wb_valid;
  assign base_wb_reg = r.rn;
  assign base_wb_data = r.new_base;
  assign branch_valid = r.branch_valid;
  assign branch_target = r.branch_target;
  // Flags never written by these instructions
  assign flags_write = 1'b0;
  assign imm_error = r.imm_error;
  assign done = r.done;

endmodule : lsag_unit

// [test/lsag_chk.sv]
// Checker of request, access and write-back timing of the address unit
`timescale 1ns/1ps
module lsag_chk
  import lsag_pkg::*;
(
  // Clock and request
  input wire logic sys_clk, rst_n, clk_en, req_valid, req_ready,
  input wire lsag_op_t req_op,
  input wire lsag_mode_t req_mode,
  input wire lsag_size_t req_size,
  input wire logic signed [13:0] req_imm,
  input wire logic [31:0] pc_value, base_value,
  // Results
  input wire logic [31:0] mem_addr, wb_data, branch_target,
  input wire logic mem_valid, wb_valid, branch_valid, base_wb_valid,
  input wire logic flags_write, imm_error, done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire tk = clk_en && req_valid && req_ready;
  wire ld = tk && req_op != LSAG_OP_PCREL && req_size != LSAG_SZ_DUAL;
  wire pcr = tk && req_op == LSAG_OP_PCREL;
  wire okpc = req_imm >= LSAG_PCREL_MIN && req_imm <= LSAG_PCREL_MAX;
  wire ok1 = req_imm >= LSAG_OFS_MIN && req_imm <= LSAG_IDX_MAX;
  wire [31:0] pcsum = pc_value + 32'(req_imm);
  wire [31:0] ofsum = base_value + 32'(req_imm);
  property p_flags; !flags_write; endproperty
  a_flags: assert property (p_flags) else $error("flags written");
  property p_pcrel; pcr && okpc |=> wb_valid && done && wb_data == $past(pcsum); endproperty
  a_pcrel: assert property (p_pcrel) else $error("pc sum wrong");
  property p_pcbad; pcr && !okpc |=> imm_error && !wb_valid; endproperty
  a_pcbad: assert property (p_pcbad) else $error("pc range");
  property p_idx; ld && req_mode != LSAG_MODE_OFFSET && req_imm > LSAG_IDX_MAX |=> imm_error && !mem_valid; endproperty
  a_idx: assert property (p_idx) else $error("index range");
  property p_dual; tk && req_op != LSAG_OP_PCREL && req_size == LSAG_SZ_DUAL && req_imm[1:0] != 2'h0 |=> imm_error;
  endproperty
  a_dual: assert property (p_dual) else $error("dual step");
  property p_ofs; ld && req_mode == LSAG_MODE_OFFSET && ok1 |=> mem_valid && mem_addr == $past(ofsum);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset addr");
  property p_pre; ld && req_mode == LSAG_MODE_PRE && ok1 |=> mem_valid && mem_addr == $past(ofsum); endproperty
  a_pre: assert property (p_pre) else $error("pre addr");
  property p_post; ld && req_mode == LSAG_MODE_POST && ok1 |=> mem_valid && mem_addr == $past(base_value); endproperty
  a_post: assert property (p_post) else $error("post addr");
  property p_br; branch_valid |-> !branch_target[0] && !wb_valid; endproperty
  a_br: assert property (p_br) else $error("branch bit");
  property p_bwb; base_wb_valid |-> done; endproperty
  a_bwb: assert property (p_bwb) else $error("late base");
endmodule : lsag_chk
bind lsag_unit lsag_chk u_chk (.*);

// [test/lsag_mem.sv]
// Behavioural data memory answering the unit's access port
`timescale 1ns/1ps
module lsag_mem (
  // Access port
  input wire logic sys_clk, clk_en, mem_valid, mem_write, slow,
  input wire logic [31:0] mem_addr, mem_wdata,
  output logic mem_ready = '0,
  output logic [31:0] mem_rdata = '0
);
  logic [64:0] beats[$];
  logic tog = '0;
  function automatic logic [31:0] rd(input logic [31:0] a);
    return {a[15:0] ^ 16'h9c3a, a[7:0], a[15:8] ^ 8'h5b};
  endfunction : rd
  // A beat only counts at an edge the unit is enabled on
  always @(posedge sys_clk) if (clk_en && mem_valid && mem_ready) beats.push_back({mem_write, mem_addr, mem_wdata});
  // Released data turns to its inverse
  always @(negedge sys_clk) begin
    tog <= !tog;
    mem_ready <= mem_valid && (!slow || tog);
    mem_rdata <= mem_valid ? rd(mem_addr) : ~mem_rdata;
  end
endmodule : lsag_mem

// [test/lsag_unit_tb.sv]
// Random and boundary instruction stream against a reference of the address unit
`timescale 1ns/1ps
module lsag_unit_tb;
  import lsag_pkg::*;
  logic sys_clk = '0, rst_n = '0, clk_en = '1, req_valid = '0, slow = '0;
  lsag_op_t req_op = LSAG_OP_PCREL;
  lsag_mode_t req_mode = LSAG_MODE_OFFSET;
  lsag_size_t req_size = LSAG_SZ_WORD, mem_size;
  logic [3:0] req_rt = '0, req_rt2 = '0, req_rn = '0, wb_reg, wb2_reg, base_wb_reg;
  logic signed [13:0] req_imm = '0;
  logic [31:0] pc_value = '0, base_value = '0, rt_value = '0, rt2_value = '0;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, wb_data, wb2_data, base_wb_data, branch_target;
  logic req_ready, mem_valid, mem_ready, mem_write, wb_valid, wb2_valid, base_wb_valid, branch_valid;
  logic flags_write, imm_error, done;
  int err_count = 0, total_checks = 0;
  logic [31:0] seed = 32'hf219;
  logic signed [13:0] bnd[12] = '{4095, 4096, -255, -256, 255, 256, 1020, 1024, -1020, 1018, -4095, -4096};
  lsag_unit dut (.*);
  lsag_mem mem (.*);
  initial forever #4 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [31:0] ext(input lsag_size_t s, input logic [31:0] d);
    case (s)
      LSAG_SZ_BYTE: return {24'h0, d[7:0]};
      LSAG_SZ_HALF: return {16'h0, d[15:0]};
      LSAG_SZ_SBYTE: return {{24{d[7]}}, d[7:0]};
      LSAG_SZ_SHALF: return {{16{d[15]}}, d[15:0]};
      default: return d;
    endcase
  endfunction : ext
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic run(input logic signed [13:0] imm);
    logic [31:0] r, a, ea, msk, br;
    logic [35:0] w1, w2, bw;
    logic [64:0] b;
    logic [4:0] s;
    logic ok, pcl;
    int n;
    r = rnd();
    s = '0;
    req_op = lsag_op_t'(r[1:0] % 3);
    req_mode = lsag_mode_t'(r[3:2] % 3);
    req_size = lsag_size_t'(req_op == LSAG_OP_STORE ? (r[5:4] == 2'h3 ? 5 : r[5:4]) : r[6:4] % 6);
    pcl = req_op == LSAG_OP_LOAD && req_size == LSAG_SZ_WORD && r[10];
    req_rt = pcl ? LSAG_REG_PC : {1'b0, r[9:7] % 3'h7};
    req_rt2 = req_rt + 4'h1;
    req_rn = 4'h8 + r[12:11];
    req_imm = imm;
    a = rnd();
    pc_value = req_op == LSAG_OP_PCREL ? {a[31:1], ~imm[0]} : a;
    {base_value, rt_value, rt2_value} = {rnd(), rnd(), rnd()};
    slow = r[13];
    mem.beats.delete();
    clk_en = '1;
    req_valid = '1;
    if (req_op == LSAG_OP_PCREL) ok = imm >= LSAG_PCREL_MIN && imm <= LSAG_PCREL_MAX;
    else if (req_size == LSAG_SZ_DUAL) ok = imm[1:0] == 2'h0 && imm >= LSAG_DUAL_MIN && imm <= LSAG_DUAL_MAX;
    else ok = imm >= LSAG_OFS_MIN && imm <= (req_mode == LSAG_MODE_OFFSET ? LSAG_OFS_MAX : LSAG_IDX_MAX);
    ea = base_value + 32'(imm);
    a = req_mode == LSAG_MODE_POST ? base_value : ea;
    n = !ok || req_op == LSAG_OP_PCREL ? 0 : req_size == LSAG_SZ_DUAL ? 2 : 1;
    @(negedge sys_clk);
    req_valid = '0;
    repeat (60) begin
      if (wb_valid) {s[0], w1} = {1'b1, wb_reg, wb_data};
      if (wb2_valid) {s[1], w2} = {1'b1, wb2_reg, wb2_data};
      if (base_wb_valid) {s[2], bw} = {1'b1, base_wb_reg, base_wb_data};
      if (branch_valid) {s[3], br} = {1'b1, branch_target};
      if (imm_error) s[4] = '1;
      if (mem_valid) chk(mem_size, req_size);
      if (done) break;
      clk_en = rnd() % 4 != 0;
      @(negedge sys_clk);
    end
    chk(done, 1);
    chk(req_ready, 1);
    chk(s, {!ok, pcl && ok, n > 0 && req_mode != LSAG_MODE_OFFSET, n == 2 && req_op == LSAG_OP_LOAD,
            ok && (req_op == LSAG_OP_PCREL || req_op == LSAG_OP_LOAD && !pcl)});
    if (ok && req_op == LSAG_OP_PCREL) chk(w1, {req_rt, pc_value + 32'(imm)});
    if (s[2]) chk(bw, {req_rn, ea});
    chk(mem.beats.size(), n);
    msk = req_size == LSAG_SZ_BYTE ? 32'hff : req_size == LSAG_SZ_HALF ? 32'hffff : 32'hffffffff;
    for (int k = 0; k < n && mem.beats.size() > 0; k++) begin
      b = mem.beats.pop_front();
      chk(b[64:32], {req_op == LSAG_OP_STORE, a + 32'(4 * k)});
      if (req_op == LSAG_OP_STORE) chk(b[31:0] & msk, (k > 0 ? rt2_value : rt_value) & msk);
    end
    if (n > 0 && req_op == LSAG_OP_LOAD) begin
      if (pcl) chk(br, mem.rd(a) & ~32'h1);
      else chk(w1, {req_rt, ext(req_size, mem.rd(a))});
      if (n == 2) chk(w2, {req_rt2, mem.rd(a + 32'h4)});
    end
  endtask : run
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = '1;
    for (int i = 0; i < 400; i++) run(i < 96 ? bnd[i % 12] : 14'($signed(rnd()) >>> (18 + rnd() % 6)));
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    wrap_up();
  end
endmodule : lsag_unit_tb
